// File: hw/audio_pll_host.v
// Purpose: host controller that programs the amplifier clock tree over its two-wire port
// Assumes: apb slave with one wait state; device on page 0 after a page write
// Notes: coefficients are checked before any device write is issued, unless pll_on was clear before the start write
// How it works
// [R1] ref source field goes to register 13
// [R2] pll off means host supplies system clock
// [R3] pll on is the reset state here
// [R4] output is input times R times J.D over P
// [R5] reference must lie in 512 kHz..50 MHz
// [R6] P written to register 20 bits 3:0
// [R7] J written to register 21 bits 5:0
// [R8] fraction split over registers 22 and 23
// [R9] R written to register 24 bits 3:0
// [R10] integer mode limits checked before programming
// [R11] fractional mode limits checked, R must be one
// [R12] sample rate is pll output over 2048
// [R13] processing divider written to register 27
// [R14] modulator divider written to register 28
// [R15] charge pump divider written to register 29
// [R16] oversampling divider gives sixteen times sample rate
// [R17] bit clock out divider to register 32
// [R18] word clock out divider to register 33
// [R19] bit clock reference is 32 or 64 fs
// [R20] internal reference is source over P
// [R21] all clock registers written before pll enable
// [R22] with pll off, dividers run from system clock
`include "pll_host_map.vh"
module audio_pll_host #(
    parameter       QTR      = 16,
    parameter [6:0] DEV_ADDR = 7'h4c
) (
    input  wire        i_clk,
    input  wire        i_resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        i_sda_in,
    output wire        o_sda_out,
    output wire        o_sda_oe,
    output wire        o_scl_out,
    output wire        o_scl_oe,
    output reg         o_sclk_needed
);
    localparam [1:0] Q_IDLE = 2'h0;
    localparam [1:0] Q_ISSUE = 2'h1;
    localparam [1:0] Q_WAIT = 2'h2;

    reg         pll_on;
    reg  [2:0]  ref_src;
    reg  [3:0]  pre_divide_value;
    reg  [5:0]  integer_mult_value;
    reg  [13:0] fraction_mult_value;
    reg  [3:0]  r_mult_value;
    reg  [6:0]  proc_clk_div;
    reg  [6:0]  modulator_clk_div;
    reg  [6:0]  charge_pump_clk_div;
    reg  [6:0]  oversample_clk_div;
    reg  [6:0]  bit_clk_out_div;
    reg  [7:0]  word_clk_out_div;
    reg  [15:0] ref_khz;
    reg         busy;
    reg         done;
    reg         nack;
    reg         cfg_err;
    reg  [1:0]  qstate;
    reg  [3:0]  idx;
    reg         go;
    reg  [7:0]  seq_reg;
    reg  [7:0]  seq_data;
    wire        wr_busy;
    wire        wr_done;
    wire        wr_nack;

    // coefficient decode: a zero P or R field stands for sixteen
    wire [4:0]  p_val = (pre_divide_value == 4'h0) ? 5'h10 : {1'b0, pre_divide_value};
    wire [4:0]  r_val = (r_mult_value == 4'h0) ? 5'h10 : {1'b0, r_mult_value};
    wire        frac = (fraction_mult_value != 14'h0000);
    wire [19:0] k_x = integer_mult_value * `FRAC_SCALE + {6'h00, fraction_mult_value};
    // internal reference compared as ref against limits times P  [R20]
    wire [21:0] p_min_int = p_val * `PREF_MIN_INT_KHZ;
    wire [31:0] p_min_frac = p_val * `PREF_MIN_FRAC_HZ;
    wire [21:0] p_max = p_val * `PREF_MAX_KHZ;
    wire [25:0] ref_hz_k = ref_khz * 10'd1000;
    // pll output times P times 10000 in kHz  [R4]
    wire [47:0] out_x = ref_khz * r_val * k_x;
    wire [47:0] out_lo = p_val * `OUT_MIN_KHZ * `FRAC_SCALE;
    wire [47:0] out_hi = p_val * `OUT_MAX_KHZ * `FRAC_SCALE;
    wire        ref_ok = ({1'b0, ref_khz} >= `REF_MIN_KHZ) && ({1'b0, ref_khz} <= `REF_MAX_KHZ); // [R5]
    wire        pref_ok = frac ? ({6'h00, ref_hz_k} >= p_min_frac) && ({6'h00, ref_khz} <= p_max)
                               : ({6'h00, ref_khz} >= p_min_int) && ({6'h00, ref_khz} <= p_max);
    wire        out_ok = (out_x >= out_lo) && (out_x <= out_hi); // [R10] [R11]
    wire        j_ok = frac ? (integer_mult_value >= `J_MIN_FRAC) && (integer_mult_value <= `J_MAX_FRAC)
                                && (r_val == 5'h01)                                        // [R11]
                            : (integer_mult_value >= `J_MIN_INT);                          // [R10]
    wire        d_ok = (fraction_mult_value <= `FRAC_MAX);
    wire [13:0] osr_prod = modulator_clk_div * oversample_clk_div;
    wire        osr_ok = (osr_prod == `OSR_PRODUCT); // [R16]
    // bypass mode skips pll limits; the host then provides the system clock  [R2]
    wire        cfg_ok = osr_ok && (!pll_on || (ref_ok && pref_ok && out_ok && j_ok && d_ok));
    wire        acc = psel && penable && pready;
    wire        wr = acc && pwrite;
    wire        start_req = wr && (paddr == `A_CTRL) && pwdata[`CTRL_START];

    // write order: page, pll off, source, coefficients, dividers, pll enable last  [R21]
    always @* begin
        seq_reg = `DEV_PAGE_SEL;
        seq_data = `DEV_PAGE_ZERO;
        case (idx)
            4'h1: begin
                seq_reg = `DEV_PLL_ENABLE_CTRL;
                seq_data = 8'h00;
            end
            4'h2: begin
                seq_reg = `DEV_PLL_REF_SELECT;
                seq_data = {1'b0, ref_src, 4'h0}; // [R1] [R19]
            end
            4'h3: begin
                seq_reg = `DEV_PLL_PRE_DIVIDER;
                seq_data = {4'h0, pre_divide_value}; // [R6]
            end
            4'h4: begin
                seq_reg = `DEV_PLL_INTEGER_MULT;
                seq_data = {2'h0, integer_mult_value}; // [R7]
            end
            4'h5: begin
                seq_reg = `DEV_PLL_FRACTION_HI;
                seq_data = {2'h0, fraction_mult_value[13:8]}; // [R8]
            end
            4'h6: begin
                seq_reg = `DEV_PLL_FRACTION_LO;
                seq_data = fraction_mult_value[7:0]; // [R8]
            end
            4'h7: begin
                seq_reg = `DEV_PLL_R_MULT;
                seq_data = {4'h0, r_mult_value}; // [R9]
            end
            4'h8: begin
                seq_reg = `DEV_PROC_CLK_DIV;
                seq_data = {1'b0, proc_clk_div}; // [R13]
            end
            4'h9: begin
                seq_reg = `DEV_MOD_CLK_DIV;
                seq_data = {1'b0, modulator_clk_div}; // [R14]
            end
            4'ha: begin
                seq_reg = `DEV_CP_CLK_DIV;
                seq_data = {1'b0, charge_pump_clk_div}; // [R15]
            end
            4'hb: begin
                seq_reg = `DEV_OSR_CLK_DIV;
                seq_data = {1'b0, oversample_clk_div}; // [R16]
            end
            4'hc: begin
                seq_reg = `DEV_BCK_OUT_DIV;
                seq_data = {1'b0, bit_clk_out_div}; // [R17]
            end
            4'hd: begin
                seq_reg = `DEV_WCK_OUT_DIV;
                seq_data = word_clk_out_div; // [R18]
            end
            4'he: begin
                seq_reg = `DEV_PLL_ENABLE_CTRL;
                seq_data = {7'h00, pll_on}; // [R2]
            end
            default: begin
                seq_reg = `DEV_PAGE_SEL;
                seq_data = `DEV_PAGE_ZERO;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pll_on <= 1'b1; // [R3]
            ref_src <= `SRC_SCLK;
            pre_divide_value <= 4'h1;
            integer_mult_value <= 6'h00;
            fraction_mult_value <= 14'h0000;
            r_mult_value <= 4'h1;
            proc_clk_div <= 7'h00;
            modulator_clk_div <= 7'h00;
            charge_pump_clk_div <= 7'h00;
            oversample_clk_div <= 7'h00;
            bit_clk_out_div <= 7'h00;
            word_clk_out_div <= 8'h00;
            ref_khz <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
            nack <= 1'b0;
            cfg_err <= 1'b0;
            qstate <= Q_IDLE;
            idx <= 4'h0;
            go <= 1'b0;
            o_sclk_needed <= 1'b0;
        end else begin
            // one wait state keeps read data registered
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                pslverr <= (paddr > `A_REF_KHZ) || (paddr[1:0] != 2'h0);
                // writes leave read data alone, so it holds until the next read
                if (!pwrite) begin
                    case (paddr)
                        `A_CTRL: prdata <= {25'h0, ref_src, 2'h0, pll_on, 1'b0};
                        `A_STATUS: prdata <= {28'h0, cfg_err, nack, done, busy};
                        `A_PLL: prdata <= {12'h0, r_mult_value, 2'h0, integer_mult_value, 4'h0, pre_divide_value};
                        `A_FRAC: prdata <= {18'h0, fraction_mult_value};
                        `A_DIV0: prdata <= {1'b0, oversample_clk_div, 1'b0, charge_pump_clk_div,
                                            1'b0, modulator_clk_div, 1'b0, proc_clk_div};
                        `A_DIV1: prdata <= {16'h0, word_clk_out_div, 1'b0, bit_clk_out_div};
                        `A_REF_KHZ: prdata <= {16'h0, ref_khz};
                        default: prdata <= 32'h00000000;
                    endcase
                end
            end
            // settings are locked while a sequence runs
            if (wr && !busy) begin
                case (paddr)
                    `A_CTRL: begin
                        pll_on <= pwdata[`CTRL_PLL_ON];
                        ref_src <= pwdata[`CTRL_SRC_LSB + 2:`CTRL_SRC_LSB];
                    end
                    `A_PLL: begin
                        pre_divide_value <= pwdata[3:0];
                        integer_mult_value <= pwdata[13:8];
                        r_mult_value <= pwdata[19:16];
                    end
                    `A_FRAC: fraction_mult_value <= pwdata[13:0];
                    `A_DIV0: begin
                        proc_clk_div <= pwdata[6:0];
                        modulator_clk_div <= pwdata[14:8];
                        charge_pump_clk_div <= pwdata[22:16];
                        oversample_clk_div <= pwdata[30:24];
                    end
                    `A_DIV1: begin
                        bit_clk_out_div <= pwdata[6:0];
                        word_clk_out_div <= pwdata[15:8];
                    end
                    `A_REF_KHZ: ref_khz <= pwdata[15:0];
                    default: ;
                endcase
            end
            // write one clears; a hardware set in the same cycle wins
            if (wr && paddr == `A_STATUS) begin
                if (pwdata[`ST_DONE])
                    done <= 1'b0;
                if (pwdata[`ST_NACK])
                    nack <= 1'b0;
                if (pwdata[`ST_CFG_ERR])
                    cfg_err <= 1'b0;
            end
            go <= 1'b0;
            case (qstate)
                Q_IDLE: if (start_req && !busy) begin
                    if (cfg_ok) begin // [R10] [R11] [R5]
                        busy <= 1'b1;
                        idx <= 4'h0;
                        qstate <= Q_ISSUE;
                    end else begin
                        cfg_err <= 1'b1;
                    end
                end
                Q_ISSUE: if (!wr_busy) begin
                    go <= 1'b1;
                    qstate <= Q_WAIT;
                end
                Q_WAIT: if (wr_done) begin
                    if (wr_nack) begin
                        nack <= 1'b1;
                        busy <= 1'b0;
                        qstate <= Q_IDLE;
                    end else if (idx == `SEQ_LEN) begin
                        done <= 1'b1;
                        busy <= 1'b0;
                        o_sclk_needed <= !pll_on; // [R22]
                        qstate <= Q_IDLE;
                    end else begin
                        idx <= idx + 4'h1;
                        qstate <= Q_ISSUE;
                    end
                end
                default: qstate <= Q_IDLE;
            endcase
        end
    end

    // the writer latches register and data on go, so the table may move on
    i2c_reg_writer #(
        .QTR      (QTR),
        .DEV_ADDR (DEV_ADDR)
    ) u_writer (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_go      (go),
        .i_reg     (seq_reg),
        .i_data    (seq_data),
        .i_sda_in  (i_sda_in),
        .o_sda_out (o_sda_out),
        .o_sda_oe  (o_sda_oe),
        .o_scl_out (o_scl_out),
        .o_scl_oe  (o_scl_oe),
        .o_busy    (wr_busy),
        .o_done    (wr_done),
        .o_nack    (wr_nack)
    );
endmodule

// File: hw/pll_host_map.vh
// Purpose: register offsets, fields and constants of the audio pll host controller
// Assumes: included by bare name, definitions only
// Notes: device offsets are page 0 register numbers
`ifndef PLL_HOST_MAP_VH
`define PLL_HOST_MAP_VH

// device registers (page 0)
`define DEV_PAGE_SEL         8'h00
`define DEV_PLL_ENABLE_CTRL  8'h04
`define DEV_PLL_REF_SELECT   8'h0d
`define DEV_PLL_PRE_DIVIDER  8'h14
`define DEV_PLL_INTEGER_MULT 8'h15
`define DEV_PLL_FRACTION_HI  8'h16
`define DEV_PLL_FRACTION_LO  8'h17
`define DEV_PLL_R_MULT       8'h18
`define DEV_PROC_CLK_DIV     8'h1b
`define DEV_MOD_CLK_DIV      8'h1c
`define DEV_CP_CLK_DIV       8'h1d
`define DEV_OSR_CLK_DIV      8'h1e
`define DEV_BCK_OUT_DIV      8'h20
`define DEV_WCK_OUT_DIV      8'h21
`define DEV_PAGE_ZERO        8'h00
`define SEQ_LEN              4'he

// reference source codes in bits 6:4
`define SRC_SCLK             3'h0
`define SRC_BCLK             3'h1

// host apb registers
`define A_CTRL               8'h00
`define A_STATUS             8'h04
`define A_PLL                8'h08
`define A_FRAC               8'h0c
`define A_DIV0               8'h10
`define A_DIV1               8'h14
`define A_REF_KHZ            8'h18

// ctrl fields
`define CTRL_START           0
`define CTRL_PLL_ON          1
`define CTRL_SRC_LSB         4
// status fields
`define ST_BUSY              0
`define ST_DONE              1
`define ST_NACK              2
`define ST_CFG_ERR           3

// limits, frequencies in kHz except PREF_MIN_FRAC_HZ in Hz
`define REF_MIN_KHZ          17'd512
`define REF_MAX_KHZ          17'd50000
`define PREF_MIN_INT_KHZ     17'd1000
`define PREF_MIN_FRAC_HZ     27'd6667000
`define PREF_MAX_KHZ         17'd20000
`define OUT_MIN_KHZ          17'd64000
`define OUT_MAX_KHZ          17'd100000
`define FRAC_SCALE           14'd10000
`define FRAC_MAX             14'd9999
`define J_MIN_INT            6'd1
`define J_MIN_FRAC           6'd4
`define J_MAX_FRAC           6'd11
`define OSR_PRODUCT          14'd128

`endif

// File: hw/i2c_reg_writer.v
// Purpose: open-drain two-wire master that writes one byte to one device register
// Assumes: device acks each byte; no clock stretching
// Notes: one bit takes four quarter periods of QTR clocks each
`include "pll_host_map.vh"
module i2c_reg_writer #(
    parameter       QTR      = 16,
    parameter [6:0] DEV_ADDR = 7'h4c
) (
    input  wire       i_clk,
    input  wire       i_resetn,
    input  wire       i_go,
    input  wire [7:0] i_reg,
    input  wire [7:0] i_data,
    input  wire       i_sda_in,
    output reg        o_sda_out,
    output reg        o_sda_oe,
    output reg        o_scl_out,
    output reg        o_scl_oe,
    output reg        o_busy,
    output reg        o_done,
    output reg        o_nack
);
    localparam [1:0] S_IDLE  = 2'h0;
    localparam [1:0] S_START = 2'h1;
    localparam [1:0] S_BIT   = 2'h2;
    localparam [1:0] S_STOP  = 2'h3;

    reg [1:0]  state;
    reg [1:0]  phase;
    reg [15:0] div;
    reg [3:0]  bitn;
    reg [1:0]  byten;
    reg [23:0] sh;
    wire       tick = (div == QTR - 1);

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= S_IDLE;
            phase <= 2'h0;
            div <= 16'h0000;
            bitn <= 4'h0;
            byten <= 2'h0;
            sh <= 24'h000000;
            o_sda_out <= 1'b0;
            o_scl_out <= 1'b0;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_nack <= 1'b0;
        end else begin
            o_done <= 1'b0;
            div <= tick ? 16'h0000 : div + 16'h0001;
            case (state)
                S_IDLE: begin
                    div <= 16'h0000;
                    phase <= 2'h0;
                    if (i_go) begin
                        sh <= {DEV_ADDR, 1'b0, i_reg, i_data};
                        o_busy <= 1'b1;
                        o_nack <= 1'b0;
                        bitn <= 4'h0;
                        byten <= 2'h0;
                        state <= S_START;
                    end
                end
                S_START: if (tick) begin
                    phase <= phase + 2'h1;
                    if (phase == 2'h1)
                        o_sda_oe <= 1'b1;
                    if (phase == 2'h2)
                        o_scl_oe <= 1'b1;
                    if (phase == 2'h3) begin
                        phase <= 2'h0;
                        state <= S_BIT;
                    end
                end
                S_BIT: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: o_sda_oe <= (bitn < 4'h8) ? ~sh[23] : 1'b0;
                        2'h1: o_scl_oe <= 1'b0;
                        2'h2: if (bitn == 4'h8 && i_sda_in)
                            o_nack <= 1'b1;
                        default: begin
                            o_scl_oe <= 1'b1;
                            if (bitn == 4'h8) begin
                                bitn <= 4'h0;
                                byten <= byten + 2'h1;
                                if (byten == 2'h2)
                                    state <= S_STOP;
                            end else begin
                                bitn <= bitn + 4'h1;
                                sh <= {sh[22:0], 1'b0};
                            end
                        end
                    endcase
                end
                default: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: o_sda_oe <= 1'b1;
                        2'h1: o_scl_oe <= 1'b0;
                        2'h2: o_sda_oe <= 1'b0;
                        default: begin
                            o_busy <= 1'b0;
                            o_done <= 1'b1;
                            state <= S_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end
endmodule

// File: bench/pll_host_checker_assertions.sv
// Purpose: port checks of the pll host controller
// Assumes: QTR of 2 or more
// Notes: bound to every instance of the top module
module pll_host_checker (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        i_sda_in,
    input wire logic        o_sda_out,
    input wire logic        o_sda_oe,
    input wire logic        o_scl_out,
    input wire logic        o_scl_oe,
    input wire logic        o_sclk_needed
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    a_ready_one_wait: assert property (disable iff (!i_resetn)
        psel && penable && !pready |=> pready) else $error("pready not one cycle after access");
    a_ready_single: assert property (disable iff (!i_resetn)
        pready |=> !pready) else $error("pready longer than one cycle");
    a_err_unmapped: assert property (disable iff (!i_resetn)
        psel && penable && !pready && (paddr > 8'h18 || paddr[1:0] != 2'h0) |=> pready && pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (disable iff (!i_resetn)
        psel && penable && !pready && paddr <= 8'h18 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("error on mapped address");
    // sync reset: checked while reset is low, so no disable here
    a_reset_quiet: assert property (!i_resetn |=> !pready && !pslverr && !o_sda_oe && !o_scl_oe && !o_sclk_needed)
        else $error("outputs busy in reset");
    a_prdata_hold: assert property (disable iff (!i_resetn)
        $changed(prdata) |-> pready && !pwrite) else $error("read data moved outside a read");
    a_scl_low_hold: assert property (disable iff (!i_resetn)
        $rose(o_scl_oe) |=> o_scl_oe [*3]) else $error("clock low phase too short");
    a_sclk_bus_idle: assert property (disable iff (!i_resetn)
        $changed(o_sclk_needed) |-> !o_scl_oe && !o_sda_oe) else $error("clock need changed mid sequence");
    a_open_drain: assert property (disable iff (!i_resetn)
        !o_sda_out && !o_scl_out) else $error("open drain output driven high");
endmodule
bind audio_pll_host pll_host_checker pll_host_checker_i (.i_clk(i_clk), .i_resetn(i_resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_sclk_needed(o_sclk_needed));

// File: bench/pll_dev_model.sv
// Purpose: behavioural amplifier clock tree seen through its two-wire port
// Assumes: pulled-up wires, single byte writes
// Notes: nack input refuses every byte, to test aborts
module pll_dev_model #(
    parameter [6:0] ADDR = 7'h4c
) (
    input  wire logic i_scl,
    input  wire logic i_sda,
    input  wire logic i_nack,
    output logic      o_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [0:255];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [7:0] last;
    logic       on_us;
    int         bits;
    int         nbyte;
    int         nwr;
    wire [2:0]  ref_src = regs[13][6:4];
    wire        pll_on  = regs[4][0];    // off: dividers run from system clock
    // output = ref * R * J.D / P, fs = output / 2048; no analog loop modelled
    initial begin
        for (int k = 0; k < 256; k++) regs[k] = 8'h00;
        regs[4] = 8'h01;
        o_sda_oe = 1'b0;
        bits = 0;
        nbyte = 0;
        nwr = 0;
        on_us = 1'b0;
    end
    always @(negedge i_sda) begin
        if (i_scl) begin
            bits = 0;
            nbyte = 0;
            on_us = 1'b1;
        end
    end
    always @(posedge i_scl) begin
        if (bits < 8) begin
            sh = {sh[6:0], i_sda};
            bits++;
        end
    end
    always @(negedge i_scl) begin
        if (bits == 8) begin
            o_sda_oe = !i_nack && on_us && (nbyte != 0 || sh == {ADDR, 1'b0});
            bits = 9;
        end else if (bits == 9) begin
            o_sda_oe = 1'b0;
            bits = 0;
            if (nbyte == 0) on_us = !i_nack && sh == {ADDR, 1'b0};
            else if (nbyte == 1) ptr = sh;
            else if (nbyte == 2 && on_us && !i_nack) begin
                regs[ptr] = sh;
                last = ptr;
                nwr++;
            end
            nbyte++;
        end
    end
endmodule

// File: bench/test_audio_pll_host.sv
// Purpose: register level test of the pll host controller
// Assumes: QTR of 2 keeps sequences short
// Notes: device side checked through the model's register copy
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module test_audio_pll_host;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] DIV0 = 32'h08041002;
    localparam logic [31:0] DIV1 = 32'h00004004;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, sda_oe, scl_oe, m_oe, sclk_needed;
    logic        nack = 1'b0;
    logic [31:0] q;
    logic        e;
    int          fail_count = 0;
    int          n_tests = 0;
    int          w0;
    wire         sda = !(sda_oe | m_oe);
    wire         scl = !scl_oe;
    logic [31:0] bref [7] = '{32'd500, 32'd12288, 32'd12288, 32'd8000, 32'd8000, 32'd6000, 32'd12288};
    logic [31:0] bpll [7] = '{32'h10801, 32'h10001, 32'h10901, 32'h10c01, 32'h20401, 32'h10b01, 32'h10801};
    logic [31:0] bfr  [7] = '{32'd0, 32'd0, 32'd0, 32'd1000, 32'd1000, 32'd5000, 32'd0};
    audio_pll_host #(.QTR(2)) audio_pll_host_i (.i_clk(i_clk), .i_resetn(i_resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .i_sda_in(sda), .o_sda_out(), .o_sda_oe(sda_oe),
        .o_scl_out(), .o_scl_oe(scl_oe), .o_sclk_needed(sclk_needed));
    pll_dev_model pll_dev_model_i (.i_scl(scl), .i_sda(sda), .i_nack(nack), .o_sda_oe(m_oe));
    always #20 i_clk = ~i_clk;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1) @(posedge i_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask
    task automatic dev(input int i, input logic [7:0] x);
        `CHK(pll_dev_model_i.regs[i], x)
    endtask
    // the start write also carries pll_on and the source field; polling stops on busy low
    task automatic run(input logic [31:0] rf, pl, fr, d0, ct);
        apb(1'b1, 8'h18, rf);
        apb(1'b1, 8'h08, pl);
        apb(1'b1, 8'h0c, fr);
        apb(1'b1, 8'h10, d0);
        apb(1'b1, 8'h14, DIV1);
        apb(1'b1, 8'h00, ct | 32'h1);
        repeat (3000) begin
            apb(1'b0, 8'h04, 32'h0);
            if (q[0] === 1'b0) break;
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        rdc(8'h00, 32'h2);
        rdc(8'h08, 32'h00010001);
        apb(1'b0, 8'h1c, 32'h0);
        `CHK(e, 1'b1)
        $display("test reset values done");
        run(32'd12288, 32'h10801, 32'h0, DIV0, 32'h12);
        rdc(8'h04, 32'h2);
        dev(13, 8'h10);
        dev(20, 8'h01);
        dev(21, 8'h08);
        dev(24, 8'h01);
        dev(27, 8'h02);
        dev(28, 8'h10);
        dev(29, 8'h04);
        dev(30, 8'h08);
        dev(32, 8'h04);
        dev(33, 8'h40);
        dev(4, 8'h01);
        `CHK(pll_dev_model_i.last, 8'h04)
        `CHK(pll_dev_model_i.nwr, 15)
        $display("test integer mode done");
        apb(1'b1, 8'h04, 32'he);
        run(32'd12000, 32'h10701, 32'd5264, DIV0, 32'h00);
        dev(4, 8'h00);
        dev(13, 8'h00);
        `CHK(sclk_needed, 1'b1)
        apb(1'b1, 8'h04, 32'he);
        run(32'd12000, 32'h10701, 32'd5264, DIV0, 32'h02);
        dev(22, 8'h14);
        dev(23, 8'h90);
        dev(4, 8'h01);
        `CHK(sclk_needed, 1'b0)
        $display("test fraction and bypass done");
        for (int k = 0; k < 7; k++) begin
            w0 = pll_dev_model_i.nwr;
            apb(1'b1, 8'h04, 32'he);
            run(bref[k], bpll[k], bfr[k], (k == 6) ? 32'h04041002 : DIV0, 32'h02);
            rdc(8'h04, 32'h8);
            `CHK(pll_dev_model_i.nwr, w0)
        end
        $display("test bad settings done");
        apb(1'b1, 8'h04, 32'he);
        nack <= 1'b1;
        w0 = pll_dev_model_i.nwr;
        run(32'd12288, 32'h10801, 32'h0, DIV0, 32'h02);
        rdc(8'h04, 32'h4);
        `CHK(pll_dev_model_i.nwr, w0)
        $display("test refused byte done");
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        fail_count++;
        end_of_test();
    end
endmodule
